// ===== core/dmaxb_top.sv
// dma request crossbar: system side and dsp side, with apb select registers
// assumes request lines come from logic on clk and apb runs on clk
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dmaxb_top
	import dmaxb_pkg::*;
#(
	parameter int unsigned SYS_SRC = DMAXB_SYS_SRC,
	parameter int unsigned SYS_OUT = DMAXB_SYS_OUT,
	parameter int unsigned DSP_SRC = DMAXB_DSP_SRC,
	parameter int unsigned DSP_OUT = DMAXB_DSP_OUT
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DMAXB_ADDR_W-1:0] paddr,
	input wire logic [DMAXB_DATA_W-1:0] pwdata,
	output logic [DMAXB_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [SYS_SRC-1:0] sys_src_req,
	output logic [SYS_OUT-1:0] sys_dma_req,
	input wire logic [DSP_SRC-1:0] dsp_src_req,
	output logic [DSP_OUT-1:0] dsp_dma_req
);

	// ****************************************
	// apb decode
	// ****************************************
	wire logic setup_phase = psel & ~penable;
	wire logic access_phase = psel & penable;
	wire logic wr_strobe = access_phase & pwrite;

	wire logic [DMAXB_ADDR_W-1:0] sys_last =
		DMAXB_ADDR_W'(DMAXB_SYS_SEL_BASE +
		DMAXB_ADDR_W'((SYS_OUT - 1) / DMAXB_SYS_PER_REG) * DMAXB_WORD_STEP);
	wire logic [DMAXB_ADDR_W-1:0] dsp_last =
		DMAXB_ADDR_W'(DMAXB_DSP_SEL_BASE +
		DMAXB_ADDR_W'((DSP_OUT - 1) / DMAXB_DSP_PER_REG) * DMAXB_WORD_STEP);

	wire logic word_aligned = (paddr[1:0] == 2'b00);
	wire logic hit_sys_sel = word_aligned & (paddr >= DMAXB_SYS_SEL_BASE) &
		(paddr <= sys_last);
	wire logic hit_dsp_sel = word_aligned & (paddr >= DMAXB_DSP_SEL_BASE) &
		(paddr <= dsp_last);
	wire logic hit_sys_stat = (paddr == DMAXB_SYS_STATUS);
	wire logic hit_dsp_stat = (paddr == DMAXB_DSP_STATUS);
	wire logic mapped = hit_sys_sel | hit_dsp_sel | hit_sys_stat |
		hit_dsp_stat;
	// status words are read-only; a write to them is refused
	wire logic refused = ~mapped | (pwrite & (hit_sys_stat | hit_dsp_stat));

	// no wait states: read data is caught in the setup cycle
	assign pready = 1'b1;
	assign pslverr = access_phase & refused;

	// ****************************************
	// system side selects and muxes
	// ****************************************
	logic [SYS_OUT-1:0][DMAXB_SYS_SEL_W-1:0] sys_sel;
	logic [SYS_OUT-1:0][DMAXB_DATA_W-1:0] sys_rd_part;

	genvar gs;
	generate
		for (gs = 0; gs < SYS_OUT; gs++)
		begin : g_sys
			localparam int unsigned LSB =
				(gs % DMAXB_SYS_PER_REG) * DMAXB_SYS_SEL_W;
			localparam logic [DMAXB_ADDR_W-1:0] ADDR =
				DMAXB_ADDR_W'(DMAXB_SYS_SEL_BASE +
				DMAXB_ADDR_W'(gs / DMAXB_SYS_PER_REG) * DMAXB_WORD_STEP);
			// identity routing: output k+1 starts on source k+1
			localparam logic [DMAXB_SYS_SEL_W-1:0] RST_SEL =
				DMAXB_SYS_SEL_W'(gs);
			wire logic hit = (paddr == ADDR);

			always_ff @(posedge clk)
			begin
				if (rst)
					sys_sel[gs] <= RST_SEL;
				else if (wr_strobe & hit)
					sys_sel[gs] <= pwdata[LSB +: DMAXB_SYS_SEL_W];
			end

			// reserved bits above the last field read zero
			assign sys_rd_part[gs] = hit ?
				(DMAXB_DATA_W'(sys_sel[gs]) << LSB) : '0;

			dmaxb_sel_mux
			#(
				.N_IN(SYS_SRC),
				.SEL_W(DMAXB_SYS_SEL_W)
			)
			u_mux
			(
				.req_in(sys_src_req),
				.sel(sys_sel[gs]),
				.req_out(sys_dma_req[gs])
			);
		end
	endgenerate

	// ****************************************
	// dsp side selects and muxes
	// ****************************************
	logic [DSP_OUT-1:0][DMAXB_DSP_SEL_W-1:0] dsp_sel;
	logic [DSP_OUT-1:0][DMAXB_DATA_W-1:0] dsp_rd_part;

	genvar gd;
	generate
		for (gd = 0; gd < DSP_OUT; gd++)
		begin : g_dsp
			localparam int unsigned LSB =
				(gd % DMAXB_DSP_PER_REG) * DMAXB_DSP_SEL_W;
			localparam logic [DMAXB_ADDR_W-1:0] ADDR =
				DMAXB_ADDR_W'(DMAXB_DSP_SEL_BASE +
				DMAXB_ADDR_W'(gd / DMAXB_DSP_PER_REG) * DMAXB_WORD_STEP);
			localparam logic [DMAXB_DSP_SEL_W-1:0] RST_SEL =
				DMAXB_DSP_SEL_W'(gd);
			wire logic hit = (paddr == ADDR);

			always_ff @(posedge clk)
			begin
				if (rst)
					dsp_sel[gd] <= RST_SEL;
				else if (wr_strobe & hit)
					dsp_sel[gd] <= pwdata[LSB +: DMAXB_DSP_SEL_W];
			end

			assign dsp_rd_part[gd] = hit ?
				(DMAXB_DATA_W'(dsp_sel[gd]) << LSB) : '0;

			// full mux per output, so no input is tied to any output
			dmaxb_sel_mux
			#(
				.N_IN(DSP_SRC),
				.SEL_W(DMAXB_DSP_SEL_W)
			)
			u_mux
			(
				.req_in(dsp_src_req),
				.sel(dsp_sel[gd]),
				.req_out(dsp_dma_req[gd])
			);
		end
	endgenerate

	// ****************************************
	// read data
	// ****************************************
	logic [DMAXB_DATA_W-1:0] sel_rd;

	always_comb
	begin
		sel_rd = '0;
		for (int i = 0; i < SYS_OUT; i++)
			sel_rd = sel_rd | sys_rd_part[i];
		for (int j = 0; j < DSP_OUT; j++)
			sel_rd = sel_rd | dsp_rd_part[j];
	end

	// status words show the live crossbar outputs
	wire logic [DMAXB_DATA_W-1:0] sys_stat_rd = DMAXB_DATA_W'(sys_dma_req);
	wire logic [DMAXB_DATA_W-1:0] dsp_stat_rd = DMAXB_DATA_W'(dsp_dma_req);
	wire logic [DMAXB_DATA_W-1:0] next_prdata =
		hit_sys_stat ? sys_stat_rd :
		hit_dsp_stat ? dsp_stat_rd : sel_rd;

	always_ff @(posedge clk)
	begin
		if (rst)
			prdata <= '0;
		else if (setup_phase & ~pwrite)
			prdata <= next_prdata;
	end

endmodule

`default_nettype wire

// ===== core/dmaxb_pkg.sv
// register map, field layout and sizes of the dma request crossbar
// assumes a 32-bit apb slave with byte addresses and word-aligned registers
package dmaxb_pkg;

	// ****************************************
	// bus
	// ****************************************
	localparam int unsigned DMAXB_ADDR_W = 12;
	localparam int unsigned DMAXB_DATA_W = 32;
	localparam logic [DMAXB_ADDR_W-1:0] DMAXB_WORD_STEP = 12'h004;

	// ****************************************
	// system side: 56 sources onto 31 requests
	// ****************************************
	localparam int unsigned DMAXB_SYS_SRC = 56;
	localparam int unsigned DMAXB_SYS_OUT = 31;
	localparam int unsigned DMAXB_SYS_SEL_W = 6;
	localparam int unsigned DMAXB_SYS_PER_REG = 5;
	// first select register, holding requests 1 to 5
	localparam logic [DMAXB_ADDR_W-1:0] DMAXB_SYS_SEL_BASE = 12'h0ec;
	localparam logic [DMAXB_ADDR_W-1:0] DMAXB_SYS_SEL_21_25 = 12'h0fc;
	localparam logic [DMAXB_ADDR_W-1:0] DMAXB_SYS_SEL_26_30 = 12'h100;
	localparam logic [DMAXB_ADDR_W-1:0] DMAXB_SYS_SEL_31 = 12'h104;
	localparam logic [DMAXB_ADDR_W-1:0] DMAXB_SYS_STATUS = 12'h108;

	// ****************************************
	// dsp side: 28 sources onto 19 requests
	// ****************************************
	localparam int unsigned DMAXB_DSP_SRC = 28;
	localparam int unsigned DMAXB_DSP_OUT = 19;
	localparam int unsigned DMAXB_DSP_SEL_W = 5;
	localparam int unsigned DMAXB_DSP_PER_REG = 6;
	localparam logic [DMAXB_ADDR_W-1:0] DMAXB_DSP_SEL_BASE = 12'h0d0;
	localparam logic [DMAXB_ADDR_W-1:0] DMAXB_DSP_SEL_LAST = 12'h0dc;
	localparam logic [DMAXB_ADDR_W-1:0] DMAXB_DSP_STATUS = 12'h0e0;

endpackage

// ===== core/dmaxb_sel_mux.sv
// one crossbar output: picks one request line out of a bank of sources
// assumes sources are synchronous to the crossbar's own clock
`timescale 1ns/1ps
`default_nettype none

module dmaxb_sel_mux
#(
	parameter int unsigned N_IN = 56,
	parameter int unsigned SEL_W = 6
)
(
	input wire logic [N_IN-1:0] req_in,
	input wire logic [SEL_W-1:0] sel,
	output logic req_out
);

	// a select past the last source parks the output low
	wire logic in_range = (32'(sel) < N_IN);
	wire logic picked = req_in[sel];

	assign req_out = in_range & picked;

endmodule

`default_nettype wire

// ===== testbench/dmaxb_chk.sv
// port checker for the dma request crossbar, bound into dmaxb_top
// assumes apb and request lines share clk; rst is synchronous
`timescale 1ns/1ps
`default_nettype none
module dmaxb_chk
	import dmaxb_pkg::*;
#(
	parameter int unsigned SYS_SRC = 56,
	parameter int unsigned SYS_OUT = 31,
	parameter int unsigned DSP_SRC = 28,
	parameter int unsigned DSP_OUT = 19
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DMAXB_ADDR_W-1:0] paddr,
	input wire logic [DMAXB_DATA_W-1:0] pwdata,
	input wire logic [SYS_SRC-1:0] sys_src_req,
	input wire logic [SYS_OUT-1:0] sys_dma_req,
	input wire logic [DSP_SRC-1:0] dsp_src_req,
	input wire logic [DSP_OUT-1:0] dsp_dma_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire wr = psel && penable && pwrite;
	wire [5:0] ws = pwdata[5:0];
	wire [4:0] wd = pwdata[4:0];
	sys_reset_map_a: assert property ($past(rst) |->
		sys_dma_req == sys_src_req[SYS_OUT-1:0]) else $error("sys map");
	dsp_reset_map_a: assert property ($past(rst) |->
		dsp_dma_req == dsp_src_req[DSP_OUT-1:0]) else $error("dsp map");
	sys_quiet_a: assert property (sys_src_req == '0 |->
		sys_dma_req == '0) else $error("sys phantom request");
	dsp_quiet_a: assert property (dsp_src_req == '0 |->
		dsp_dma_req == '0) else $error("dsp phantom request");
	sys_hold_a: assert property (!$past(wr) && !$past(rst) &&
		$stable(sys_src_req) |-> $stable(sys_dma_req)) else $error("sys drift");
	dsp_hold_a: assert property (!$past(wr) && !$past(rst) &&
		$stable(dsp_src_req) |-> $stable(dsp_dma_req)) else $error("dsp drift");
	sys_last_sel_a: assert property ($past(wr && paddr == DMAXB_SYS_SEL_31) |->
		sys_dma_req[SYS_OUT-1] == ($past(ws) < SYS_SRC ?
		sys_src_req[$past(ws)] : 1'h0)) else $error("sys select 31");
	dsp_last_sel_a: assert property ($past(wr && paddr == DMAXB_DSP_SEL_LAST) |->
		dsp_dma_req[DSP_OUT-1] == ($past(wd) < DSP_SRC ?
		dsp_src_req[$past(wd)] : 1'h0)) else $error("dsp select 19");
	cover property (wr && paddr == DMAXB_SYS_SEL_31);
	cover property (dsp_dma_req[DSP_OUT-1]);
	cover property (sys_src_req == '0);
endmodule
bind dmaxb_top dmaxb_chk #(.SYS_SRC(SYS_SRC), .SYS_OUT(SYS_OUT),
	.DSP_SRC(DSP_SRC), .DSP_OUT(DSP_OUT)) chk_u (.clk(clk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .sys_src_req(sys_src_req), .sys_dma_req(sys_dma_req),
	.dsp_src_req(dsp_src_req), .dsp_dma_req(dsp_dma_req));
`default_nettype wire

// ===== testbench/dmaxb_src_model.sv
// peripheral request sources of both crossbar sides
// assumes picks change on clk; with all_on low, an out-of-range pick leaves all lines low
`timescale 1ns/1ps
`default_nettype none
module dmaxb_src_model
	import dmaxb_pkg::*;
(
	input wire logic clk,
	input wire logic all_on,
	input wire logic [5:0] pick_s,
	input wire logic [4:0] pick_d,
	output logic [DMAXB_SYS_SRC-1:0] sys_src_req,
	output logic [DMAXB_DSP_SRC-1:0] dsp_src_req
);
	always_ff @(posedge clk)
	begin
		sys_src_req <= all_on ? '1 : DMAXB_SYS_SRC'(1) << pick_s;
		dsp_src_req <= all_on ? '1 : DMAXB_DSP_SRC'(1) << pick_d;
	end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench: apb master, source model, crossbar under test
// assumes pready answers within a few cycles of the access phase
`timescale 1ns/1ps
`default_nettype none
module testbench
	import dmaxb_pkg::*;
;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, all_on = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [5:0] pick_s = 6'h3f;
	logic [4:0] pick_d = 5'h1f;
	logic pready, pslverr, er;
	logic [55:0] ss;
	logic [27:0] ds;
	logic [30:0] sys_dma_req;
	logic [18:0] dsp_dma_req;
	int failures = 0, tests_run = 0, cyc = 0;
	initial forever #12.5 clk = ~clk;
	dmaxb_src_model src_u (.clk(clk), .all_on(all_on), .pick_s(pick_s),
		.pick_d(pick_d), .sys_src_req(ss), .dsp_src_req(ds));
	dmaxb_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sys_src_req(ss),
		.sys_dma_req(sys_dma_req), .dsp_src_req(ds), .dsp_dma_req(dsp_dma_req));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	function automatic logic [31:0] pack(int first, int cnt, int w);
		pack = '0;
		for (int f = 0; f < cnt; f++) pack |= 32'(first + f) << (w * f);
	endfunction
	task route(input logic [5:0] s, input logic [4:0] d, input logic a);
		pick_s <= s;
		pick_d <= d;
		all_on <= a;
		repeat (2) @(posedge clk);
	endtask
	task t_reset;
		for (int w = 0; w < 3; w++)
		begin
			apb(1'h0, DMAXB_SYS_SEL_21_25 + 12'(4 * w), '0);
			chk("sys sel word", rd, pack(20 + 5 * w, w < 2 ? 5 : 1, 6));
		end
		for (int w = 0; w < 4; w++)
		begin
			apb(1'h0, DMAXB_DSP_SEL_BASE + 12'(4 * w), '0);
			chk("dsp sel word", rd, pack(6 * w, w < 3 ? 6 : 1, 5));
		end
	endtask
	task t_sys;
		apb(1'h1, DMAXB_SYS_SEL_21_25, 32'hc000_0000);
		apb(1'h0, DMAXB_SYS_SEL_21_25, '0);
		chk("sel 21-25 reserved", rd, '0);
		route(6'h00, 5'h1f, 1'h0);
		chk("req 21-25", 32'(sys_dma_req[24:20]), 32'h0000_001f);
		apb(1'h1, DMAXB_SYS_SEL_31, 32'hffff_fff7);
		apb(1'h0, DMAXB_SYS_SEL_31, '0);
		chk("sel 31 readback", rd, 32'h0000_0037);
		route(6'h37, 5'h1f, 1'h0);
		chk("req 31 from 56", 32'(sys_dma_req), 32'h4000_0000);
		apb(1'h1, DMAXB_SYS_SEL_31, 32'h0000_0038);
		route(6'h37, 5'h1f, 1'h1);
		chk("req 31 illegal", 32'(sys_dma_req), 32'h3fff_ffff);
		apb(1'h0, DMAXB_SYS_STATUS, '0);
		chk("sys status", rd, 32'h3fff_ffff);
		apb(1'h1, DMAXB_SYS_STATUS, '0);
		chk("status write refused", 32'(er), 32'h0000_0001);
	endtask
	task t_dsp;
		apb(1'h1, DMAXB_DSP_SEL_LAST, 32'h0000_001b);
		apb(1'h1, DMAXB_DSP_SEL_BASE, 32'h0000_0012);
		apb(1'h0, DMAXB_DSP_SEL_BASE, '0);
		chk("dsp sel readback", rd, 32'h0000_0012);
		route(6'h3f, 5'h12, 1'h0);
		chk("dsp 19 to 1", 32'(dsp_dma_req), 32'h0000_0001);
		route(6'h3f, 5'h1b, 1'h0);
		chk("dsp 28 to 19", 32'(dsp_dma_req), 32'h0004_0000);
		apb(1'h0, DMAXB_DSP_STATUS, '0);
		chk("dsp status", rd, 32'h0004_0000);
		apb(1'h0, 12'h200, '0);
		chk("unmapped refused", 32'(er), 32'h0000_0001);
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			failures++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_reset();
		t_sys();
		t_dsp();
		report_and_stop();
	end
endmodule
`default_nettype wire
